// ==== logic/vss_pkg.sv ====
/*
  Types of the voltage sweep sequencer: controller states and command codes.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package vss_pkg;
  typedef enum logic [3:0] {
    VSS_S_IDLE = 4'b0001,
    VSS_S_CHECK = 4'b0010,
    VSS_S_SETTLE = 4'b0100,
    VSS_S_MEAS = 4'b1000
  } vss_state_t;
  typedef enum logic [3:0] {
    VSS_C_NONE = 4'h0,
    VSS_C_GENERIC = 4'h1,
    VSS_C_LOCKED = 4'h2,
    VSS_C_ABORT = 4'h3,
    VSS_C_PRESET = 4'h4,
    VSS_C_BUSTRG = 4'h5,
    VSS_C_RST = 4'h6,
    VSS_C_RECALL = 4'h7,
    VSS_C_CLEAR = 4'h8,
    VSS_C_INIT = 4'h9,
    VSS_C_READQ = 4'hA,
    VSS_C_SWARM = 4'hB,
    VSS_C_SWABORT = 4'hC,
    VSS_C_HALT = 4'hD,
    VSS_C_TRIGKEY = 4'hE,
    VSS_C_SPARE = 4'hF
  } vss_cmd_t;
endpackage
`default_nettype wire

// ==== logic/vss_regs.svh ====
/*
  Register offsets, reset values, codes and timing for the voltage sweep sequencer.
  Assumes an APB slave with 32-bit data and byte addresses in the low address bits.
*/
// Behaviour
// - Reset sets arm and trigger counts to one.
// - Per point: set voltage, wait delay, then measure.
// - After last point: 0V, source off, keep measuring.
// - Sweep status bit 3 from arm to end.
// - Start voltage in range, default 0V, first point.
// - Stop voltage in range, default 10V, final point.
// - Partial last step is dropped.
// - Step above interval gives error 842 at arm.
// - Too many points or tiny step gives 841.
// - Step is an unsigned magnitude.
// - Centre and span stay coupled to start, stop.
// - Settling delay up to 999.9999s, default 1s; only writes above 24 bits are clamped, so up to 1677.7215s.
// - Arm turns source on; sweep starts next trigger.
// - Parameter checks happen only at arm.
// - Sweep abort: standby, stop storing, settings kept.
// - Sweep state query returns one while sweeping.
// - No measurements while idle.
// - Local: run at power-on, halt, trigger key.
// - Most commands wait until idle again.
// - Clear commands act at once, drop pending.
// - Abort-class commands refused during read query.
// - Locked commands during sweep raise error 840.
// - Buffer cleared at sweep start, one reading per step.
// - Arm with interlock open raises error 802.
// - Direction from stop versus start.
`ifndef VSS_REGS_SVH
`define VSS_REGS_SVH
// ==========================================================================
// Register offsets
`define VSS_A_CMD 8'h00
`define VSS_A_START 8'h04
`define VSS_A_STOP 8'h08
`define VSS_A_STEP 8'h0C
`define VSS_A_CENTER 8'h10
`define VSS_A_SPAN 8'h14
`define VSS_A_DELAY 8'h18
`define VSS_A_ARMCNT 8'h1C
`define VSS_A_TRGCNT 8'h20
`define VSS_A_STATUS 8'h24
`define VSS_A_ERROR 8'h28
`define VSS_A_POINT 8'h2C
`define VSS_A_SWSTATE 8'h30
// ==========================================================================
// Reset values, millivolts and delay ticks
`define VSS_RST_START 32'h0000_0000
`define VSS_RST_STOP 32'h0000_2710
`define VSS_RST_STEP 32'h0000_03E8
`define VSS_RST_DELAY 24'h00_2710
`define VSS_RST_COUNT 16'h0001
`define VSS_DELAY_MAX 24'h98_967F
// ==========================================================================
// Status bits, error codes, dispositions
`define VSS_ST_IDLE 0
`define VSS_ST_OPER 1
`define VSS_ST_QBUSY 2
`define VSS_ST_SWEEP 3
`define VSS_ST_ERR 4
`define VSS_ST_PEND 5
`define VSS_ST_DISP 8
`define VSS_ERR_LOCK 16'h0348
`define VSS_ERR_SMALL 16'h0349
`define VSS_ERR_BIG 16'h034A
`define VSS_ERR_INTLK 16'h0322
`define VSS_D_EXEC 2'h0
`define VSS_D_DEFER 2'h1
`define VSS_D_REFUSE 2'h2
`define VSS_D_ERROR 2'h3
// ==========================================================================
// Timing
`define VSS_CLK_PERIOD_NS 50
`define VSS_DLY_UNIT_NS 100000
`define VSS_DLY_TICK_CYC (`VSS_DLY_UNIT_NS / `VSS_CLK_PERIOD_NS)
`define VSS_MAX_PTS 3000
`endif

// ==== logic/vss_sequencer.sv ====
/*
  Voltage sweep sequencer with idle/initiate gate of the measurement loop.
  Assumes an APB master on clk_sys_i, a measurement engine that answers
  meas_req_o with meas_done_i, and a reading buffer fed by the store strobe.
*/
`include "vss_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module vss_sequencer
  import vss_pkg::*;
#(
  parameter int MAX_PTS = `VSS_MAX_PTS,
  parameter logic [31:0] MIN_STEP_MV = 32'h0000_0001,
  parameter int DLY_TICK_CYC = `VSS_DLY_TICK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic remote_i,
  input wire logic interlock_open_i,
  input wire logic meas_done_i,
  output logic [31:0] src_level_o,
  output logic src_operate_o,
  output logic meas_req_o,
  output logic buf_clear_o,
  output logic buf_store_o,
  output logic [31:0] buf_volt_o,
  output logic idle_o,
  output logic cmd_exec_o,
  output logic [3:0] cmd_code_o
);
  // ========================================================================
  // Declarations
  function automatic logic vss_hit(input logic [7:0] a);
    vss_hit = (a[1:0] == 2'h0) && (a <= `VSS_A_SWSTATE);
  endfunction

  vss_state_t st_q, st_d;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rdata;
  // Voltages are signed millivolts; the delay counts 100 us ticks.
  logic signed [31:0] start_q, stop_q, lvl_q, volt_q;
  logic [31:0] step_q, stp_q;
  logic [23:0] dly_q, dly_left_q;
  logic [11:0] pre_q;
  logic [15:0] armcnt_q, trgcnt_q, arm_left_q, trg_left_q;
  logic [15:0] n_q, pt_idx_q, pt_tot_q, err_q;
  logic [32:0] acc_q;
  logic sweep_q, oper_q, up_q, qbusy_q, pend_q, boot_q, idle_q;
  logic meas_req_q, clr_q, store_q, exec_q;
  logic [1:0] disp_q;
  vss_cmd_t pend_c_q, exc_q;

  // ========================================================================
  // APB decode
  wire setup = psel_i & penable_i & ~pready_q;
  wire acc = psel_i & penable_i & pready_q;
  wire wr = acc & pwrite_i & vss_hit(paddr_i);
  wire cmd_w = wr & (paddr_i == `VSS_A_CMD);
  wire vss_cmd_t code = vss_cmd_t'(pwdata_i[3:0]);
  wire signed [31:0] wdat = $signed(pwdata_i);
  wire signed [31:0] span_w = stop_q - start_q;
  wire signed [31:0] center_w = start_q + (span_w >>> 1);
  wire signed [31:0] c_start = wdat - (span_w >>> 1);
  wire signed [31:0] s_start = center_w - (wdat >>> 1);
  wire dir_up = stop_q >= start_q;
  wire [31:0] iv = dir_up ? 32'(stop_q - start_q) : 32'(start_q - stop_q);

  // ========================================================================
  // Command dispositions
  wire busy = st_q != VSS_S_IDLE;
  wire is_ab = code inside {VSS_C_ABORT, VSS_C_PRESET, VSS_C_BUSTRG,
                            VSS_C_RST, VSS_C_RECALL};
  wire urgent = code inside {VSS_C_CLEAR, VSS_C_SWABORT, VSS_C_HALT};
  wire locked = cmd_w & (code == VSS_C_LOCKED) & sweep_q;
  wire refused = busy & is_ab & qbusy_q;
  wire now_ok = ~busy | urgent | (is_ab & ~qbusy_q);
  wire do_now = cmd_w & ~locked & now_ok;
  wire defer = cmd_w & ~locked & ~now_ok & ~refused;
  wire pend_fire = ~busy & pend_q & ~cmd_w;
  wire ex_v = do_now | pend_fire;
  wire vss_cmd_t ex_c = pend_fire ? pend_c_q : code;
  wire ex_rst = ex_v & (ex_c inside {VSS_C_RST, VSS_C_PRESET});
  wire ex_swab = ex_v & (ex_c == VSS_C_SWABORT) | ex_rst;
  wire ex_idle = ex_v & (ex_c inside {VSS_C_CLEAR, VSS_C_ABORT, VSS_C_HALT,
                                      VSS_C_SWABORT}) | ex_rst;
  wire ex_arm = ex_v & (ex_c == VSS_C_SWARM);
  wire ex_rq = ex_v & (ex_c == VSS_C_READQ);
  wire ex_go = ex_v & ~busy & ((ex_c inside {VSS_C_INIT, VSS_C_READQ})
               | ((ex_c == VSS_C_TRIGKEY) & ~remote_i));
  wire go = ex_go | (boot_q & ~remote_i);
  wire cnt_w = wr & (paddr_i inside {`VSS_A_ARMCNT, `VSS_A_TRGCNT});
  wire cnt_lock = cnt_w & sweep_q;

  // ========================================================================
  // Arm checks and point bookkeeping
  wire [32:0] acc_nx = acc_q + {1'b0, step_q};
  wire chk_small = step_q < MIN_STEP_MV;
  wire chk_big = step_q > iv;
  wire chk_end = acc_nx > {1'b0, iv};
  wire chk_many = (n_q + 16'h0001) >= 16'(MAX_PTS);
  wire chk_ok = ~chk_small & ~chk_big & chk_end;
  wire chk_e841 = chk_small | (~chk_big & ~chk_end & chk_many);
  wire chk_done = chk_ok | chk_e841 | (~chk_small & chk_big);
  wire last_pt = (pt_idx_q + 16'h0001) == pt_tot_q;
  wire tr_last = (trgcnt_q != 16'h0000) & (trg_left_q == 16'h0001);
  wire ar_last = (armcnt_q != 16'h0000) & (arm_left_q == 16'h0001);
  wire m_done = (st_q == VSS_S_MEAS) & meas_done_i;
  wire sw_cont = sweep_q & ~last_pt;
  wire enter_st = (st_d == VSS_S_SETTLE) & (st_q != VSS_S_SETTLE);

  // ========================================================================
  // Controller
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      VSS_S_IDLE: begin
        if (go) begin
          st_d = sweep_q ? VSS_S_SETTLE : VSS_S_MEAS;
        end
      end
      VSS_S_CHECK: begin
        if (chk_done) begin
          st_d = VSS_S_IDLE;
        end
      end
      VSS_S_SETTLE: begin
        if (dly_left_q == 24'h00_0000) begin
          st_d = VSS_S_MEAS;
        end
      end
      VSS_S_MEAS: begin
        if (meas_done_i) begin
          if (tr_last & ar_last) begin
            st_d = VSS_S_IDLE;
          end else begin
            st_d = sw_cont ? VSS_S_SETTLE : VSS_S_MEAS;
          end
        end
      end
    endcase
    if (ex_arm) begin
      st_d = interlock_open_i ? VSS_S_IDLE : VSS_S_CHECK;
    end else if (ex_idle) begin
      st_d = VSS_S_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_q <= VSS_S_IDLE;
      boot_q <= 1'b1;
      idle_q <= 1'b1;
      meas_req_q <= 1'b0;
    end else begin
      st_q <= st_d;
      boot_q <= 1'b0;
      idle_q <= st_d == VSS_S_IDLE;
      meas_req_q <= (st_d == VSS_S_MEAS) & ((st_q != VSS_S_MEAS) | meas_done_i);
    end
  end

  // The loop counters restart from the programmed counts on every exit from
  // idle, so a sweep never alters the programmed trigger settings.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      arm_left_q <= `VSS_RST_COUNT;
      trg_left_q <= `VSS_RST_COUNT;
    end else if (st_q == VSS_S_IDLE) begin
      arm_left_q <= armcnt_q;
      trg_left_q <= trgcnt_q;
    end else if (m_done) begin
      trg_left_q <= tr_last ? trgcnt_q : trg_left_q - 16'h0001;
      arm_left_q <= tr_last ? arm_left_q - 16'h0001 : arm_left_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dly_left_q <= 24'h00_0000;
      pre_q <= 12'h000;
    end else if (enter_st) begin
      dly_left_q <= dly_q;
      pre_q <= 12'(DLY_TICK_CYC - 1);
    end else if (st_q == VSS_S_SETTLE) begin
      pre_q <= (pre_q == 12'h000) ? 12'(DLY_TICK_CYC - 1) : pre_q - 12'h001;
      if (pre_q == 12'h000) begin
        dly_left_q <= dly_left_q - 24'h00_0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || st_q != VSS_S_CHECK) begin
      acc_q <= 33'h0_0000_0000;
      n_q <= 16'h0000;
    end else begin
      acc_q <= acc_nx;
      n_q <= n_q + 16'h0001;
    end
  end

  // ========================================================================
  // Sweep engine
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || ex_swab) begin
      sweep_q <= 1'b0;
      oper_q <= 1'b0;
      lvl_q <= 32'sh0000_0000;
      pt_idx_q <= 16'h0000;
    end else if (st_q == VSS_S_CHECK && chk_ok) begin
      sweep_q <= 1'b1;
      oper_q <= 1'b1;
      lvl_q <= start_q;
      pt_idx_q <= 16'h0000;
    end else if (m_done && sweep_q) begin
      if (last_pt) begin
        sweep_q <= 1'b0;
        oper_q <= 1'b0;
        lvl_q <= 32'sh0000_0000;
      end else begin
        lvl_q <= up_q ? lvl_q + $signed(stp_q) : lvl_q - $signed(stp_q);
        pt_idx_q <= pt_idx_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pt_tot_q <= 16'h0000;
      stp_q <= 32'h0000_0000;
      up_q <= 1'b1;
    end else if (st_q == VSS_S_CHECK && chk_ok) begin
      pt_tot_q <= n_q + 16'h0001;
      stp_q <= step_q;
      up_q <= dir_up;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      clr_q <= 1'b0;
      store_q <= 1'b0;
      volt_q <= 32'sh0000_0000;
    end else begin
      clr_q <= enter_st & (st_q == VSS_S_IDLE) & (pt_idx_q == 16'h0000);
      store_q <= m_done & sweep_q;
      if (m_done && sweep_q) begin
        volt_q <= lvl_q;
      end
    end
  end

  // ========================================================================
  // Parameters; nothing is checked here, only when the sweep is armed.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || ex_rst) begin
      start_q <= `VSS_RST_START;
      stop_q <= `VSS_RST_STOP;
      step_q <= `VSS_RST_STEP;
      dly_q <= `VSS_RST_DELAY;
      armcnt_q <= `VSS_RST_COUNT;
      trgcnt_q <= `VSS_RST_COUNT;
    end else if (wr) begin
      unique case (paddr_i)
        `VSS_A_START: start_q <= wdat;
        `VSS_A_STOP: stop_q <= wdat;
        `VSS_A_STEP: step_q <= pwdata_i;
        `VSS_A_CENTER: begin
          start_q <= c_start;
          stop_q <= c_start + span_w;
        end
        `VSS_A_SPAN: begin
          start_q <= s_start;
          stop_q <= s_start + wdat;
        end
        `VSS_A_DELAY: dly_q <= (pwdata_i[31:24] != 8'h00) ? `VSS_DELAY_MAX : pwdata_i[23:0];
        `VSS_A_ARMCNT: armcnt_q <= sweep_q ? armcnt_q : pwdata_i[15:0];
        `VSS_A_TRGCNT: trgcnt_q <= sweep_q ? trgcnt_q : pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Command bookkeeping and errors
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pend_q <= 1'b0;
      pend_c_q <= VSS_C_NONE;
      qbusy_q <= 1'b0;
      disp_q <= `VSS_D_EXEC;
      exec_q <= 1'b0;
      exc_q <= VSS_C_NONE;
    end else begin
      if (defer) begin
        pend_q <= 1'b1;
        pend_c_q <= code;
      end else if (pend_fire || (ex_v && ex_c == VSS_C_CLEAR)) begin
        pend_q <= 1'b0;
      end
      qbusy_q <= (qbusy_q | (ex_go & ex_rq)) & (st_d != VSS_S_IDLE);
      if (cmd_w) begin
        disp_q <= locked ? `VSS_D_ERROR : refused ? `VSS_D_REFUSE :
                  defer ? `VSS_D_DEFER : `VSS_D_EXEC;
      end
      exec_q <= ex_v;
      exc_q <= ex_c;
    end
  end

  // A new error wins over a clear written in the same cycle.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      err_q <= 16'h0000;
    end else if (locked || cnt_lock) begin
      err_q <= `VSS_ERR_LOCK;
    end else if (ex_arm && interlock_open_i) begin
      err_q <= `VSS_ERR_INTLK;
    end else if (st_q == VSS_S_CHECK && chk_e841) begin
      err_q <= `VSS_ERR_SMALL;
    end else if (st_q == VSS_S_CHECK && chk_done && !chk_ok) begin
      err_q <= `VSS_ERR_BIG;
    end else if (wr && paddr_i == `VSS_A_ERROR) begin
      err_q <= 16'h0000;
    end
  end

  // ========================================================================
  // APB read side
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr_i)
      `VSS_A_START: rdata = start_q;
      `VSS_A_STOP: rdata = stop_q;
      `VSS_A_STEP: rdata = step_q;
      `VSS_A_CENTER: rdata = center_w;
      `VSS_A_SPAN: rdata = span_w;
      `VSS_A_DELAY: rdata = {8'h00, dly_q};
      `VSS_A_ARMCNT: rdata = {16'h0000, armcnt_q};
      `VSS_A_TRGCNT: rdata = {16'h0000, trgcnt_q};
      `VSS_A_STATUS: begin
        rdata[`VSS_ST_IDLE] = idle_q;
        rdata[`VSS_ST_OPER] = oper_q;
        rdata[`VSS_ST_QBUSY] = qbusy_q;
        rdata[`VSS_ST_SWEEP] = sweep_q;
        rdata[`VSS_ST_ERR] = err_q != 16'h0000;
        rdata[`VSS_ST_PEND] = pend_q;
        rdata[`VSS_ST_DISP+:2] = disp_q;
      end
      `VSS_A_ERROR: rdata = {16'h0000, err_q};
      `VSS_A_POINT: rdata = {pt_tot_q, pt_idx_q};
      `VSS_A_SWSTATE: rdata = {31'h0000_0000, sweep_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises on the second access cycle.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~vss_hit(paddr_i);
      if (setup && !pwrite_i) begin
        prdata_q <= vss_hit(paddr_i) ? rdata : 32'h0000_0000;
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign src_level_o = lvl_q;
  assign src_operate_o = oper_q;
  assign meas_req_o = meas_req_q;
  assign buf_clear_o = clr_q;
  assign buf_store_o = store_q;
  assign buf_volt_o = volt_q;
  assign idle_o = idle_q;
  assign cmd_exec_o = exec_q;
  assign cmd_code_o = exc_q;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_settled;
    (st_q == VSS_S_SETTLE) ##1 (st_q == VSS_S_MEAS);
  endsequence
  sequence s_last_done;
    m_done && sweep_q && last_pt;
  endsequence
  property p_cnt_one;
    ex_rst |=> (armcnt_q == 16'h0001) && (trgcnt_q == 16'h0001);
  endproperty
  a_cnt_one: assert property (p_cnt_one) else $error("counts not one");
  property p_settle_meas;
    s_settled |-> meas_req_q;
  endproperty
  a_settle_meas: assert property (p_settle_meas) else $error("no measure");
  property p_last_off;
    s_last_done |=> !sweep_q && !oper_q && (lvl_q == 32'sh0) ##1 !store_q;
  endproperty
  a_last_off: assert property (p_last_off) else $error("not off");
  property p_arm_on;
    $rose(sweep_q) |-> oper_q && (lvl_q == start_q) && $past(st_q == VSS_S_CHECK);
  endproperty
  a_arm_on: assert property (p_arm_on) else $error("arm wrong");
  property p_lock;
    (cmd_w && code == VSS_C_LOCKED && sweep_q) |=> err_q == `VSS_ERR_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("lock missed");
  property p_intlk;
    (ex_arm && interlock_open_i) |=> (err_q == `VSS_ERR_INTLK) && !sweep_q;
  endproperty
  a_intlk: assert property (p_intlk) else $error("interlock");
  property p_idle_quiet;
    meas_req_q |-> (st_q == VSS_S_MEAS) && !idle_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle measure");
  property p_abort;
    ex_swab |=> !oper_q && !sweep_q [*2];
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_state_q;
    (setup && !pwrite_i && paddr_i == `VSS_A_SWSTATE) |=> prdata_q == {31'h0, $past(sweep_q)};
  endproperty
  a_state_q: assert property (p_state_q) else $error("state query");
endmodule
`default_nettype wire

// ==== verif/vss_meas_model.sv ====
/*
  Measurement engine model: answers each reading request after a set latency.
  Assumes requests arrive as one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Engine
module vss_meas_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic meas_req_i,
  input wire logic [7:0] lat_i,
  output logic meas_done_o
);
  int cnt;
  logic busy;
  // A slow answer lets the bench reach the block while a sweep is running.
  always @(posedge clk_sys_i) begin
    meas_done_o <= !reset_i && !meas_req_i && busy && cnt == 0;
    if (reset_i) begin
      busy <= 1'b0;
    end else if (meas_req_i) begin
      busy <= 1'b1;
      cnt <= int'(lat_i);
    end else if (busy) begin
      if (cnt == 0) begin
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/vss_sequencer_tb.sv ====
/*
  Self-checking bench of the voltage sweep sequencer over APB.
  Assumes the engine model beside it and a 20 MHz clock.
*/
`include "vss_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module vss_sequencer_tb
  import vss_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ilk = 0, rmt = 1, last_err;
  logic [7:0] addr = 8'h00, lat = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, lvl, bvolt;
  logic rdy, serr, mdone, oper, mreq, bclr, bst, idle;
  int err_count = 0, cmp_count = 0, cyc = 0, clr_cyc = 0, gap = 0;
  logic [31:0] vq[$];
  always #25 clk = ~clk;
  vss_sequencer #(.DLY_TICK_CYC(2)) vss_sequencer_inst (.clk_sys_i(clk), .reset_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat),
    .prdata_o(rdat), .pready_o(rdy), .pslverr_o(serr), .remote_i(rmt),
    .interlock_open_i(ilk), .meas_done_i(mdone), .src_level_o(lvl), .src_operate_o(oper),
    .meas_req_o(mreq), .buf_clear_o(bclr), .buf_store_o(bst), .buf_volt_o(bvolt),
    .idle_o(idle), .cmd_exec_o(), .cmd_code_o());
  vss_meas_model vss_meas_model_inst (.clk_sys_i(clk), .reset_i(rst), .meas_req_i(mreq),
    .lat_i(lat), .meas_done_o(mdone));
  // ==========================================================================
  // Monitor of stored readings and settle time
  always @(posedge clk) begin
    cyc++;
    if (bst === 1'b1) vq.push_back(bvolt);
    if (bclr === 1'b1) begin
      clr_cyc = cyc;
      gap = 0;
    end else if (mreq === 1'b1 && gap == 0) gap = cyc - clr_cyc;
  end
  // ==========================================================================
  // Bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk);
    while (rdy !== 1'b1);
    r = rdat;
    last_err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic cmd(input vss_cmd_t c);
    wr(`VSS_A_CMD, {28'h0, c});
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_defaults();
    logic [7:0] a[8] = '{`VSS_A_START, `VSS_A_STOP, `VSS_A_STEP, `VSS_A_CENTER,
      `VSS_A_SPAN, `VSS_A_DELAY, `VSS_A_ARMCNT, `VSS_A_TRGCNT};
    logic [31:0] v[8] = '{32'h0, 32'h2710, 32'h3E8, 32'h1388, 32'h2710, 32'h2710, 32'h1, 32'h1};
    for (int i = 0; i < 8; i++) rdc(a[i], v[i]);
    rdc(`VSS_A_SWSTATE, 32'h0);
    wr(`VSS_A_CENTER, 32'h0);
    rdc(`VSS_A_START, 32'hFFFF_EC78);
    wr(`VSS_A_SPAN, 32'hFA0);
    rdc(`VSS_A_STOP, 32'h7D0);
    rdc(8'h40, 32'h0);
    chkb(last_err, 1'b1);
    chk(32'(vq.size()), 32'h0);
    $display("defaults done");
  endtask
  task automatic t_arm_err();
    logic [31:0] st[4] = '{32'h0, 32'h4E20, 32'h1, 32'h3E8};
    logic il[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [31:0] ex[4] = '{32'h349, 32'h34A, 32'h349, 32'h322};
    wr(`VSS_A_START, 32'h0);
    wr(`VSS_A_STOP, 32'h2710);
    for (int i = 0; i < 4; i++) begin
      wr(`VSS_A_ERROR, 32'h0);
      wr(`VSS_A_STEP, st[i]);
      rdc(`VSS_A_ERROR, 32'h0);
      ilk <= il[i];
      cmd(VSS_C_SWARM);
      repeat (3010) @(posedge clk);
      rdc(`VSS_A_ERROR, ex[i]);
      chkb(oper, 1'b0);
    end
    ilk <= 1'b0;
    $display("arm errors done");
  endtask
  task automatic t_sweep(input logic [31:0] st, input logic [31:0] sp, input int np);
    logic [31:0] r;
    int n;
    wr(`VSS_A_START, st);
    wr(`VSS_A_STOP, sp);
    wr(`VSS_A_STEP, 32'hBB8);
    wr(`VSS_A_DELAY, 32'h1);
    wr(`VSS_A_ARMCNT, 32'(np));
    cmd(VSS_C_SWARM);
    repeat (3010) @(posedge clk);
    apb(1'b0, `VSS_A_STATUS, 32'h0, r);
    chkb(r[3], 1'b1);
    chkb(oper, 1'b1);
    chk(lvl, st);
    vq.delete();
    cmd(VSS_C_INIT);
    n = 0;
    while ((vq.size() < np || idle !== 1'b1) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(vq.size()), 32'(np));
    for (int i = 0; i < np; i++) begin
      r = $signed(sp) > $signed(st) ? st + 32'(i * 3000) : st - 32'(i * 3000);
      chk(vq[i], r);
    end
    chk(32'(gap), 32'h3);
    chk(lvl, 32'h0);
    chkb(oper, 1'b0);
    rdc(`VSS_A_SWSTATE, 32'h0);
    $display("sweep done");
  endtask
  task automatic t_abort();
    int n;
    lat <= 8'h3C;
    wr(`VSS_A_DELAY, 32'h0);
    wr(`VSS_A_ARMCNT, 32'h5);
    cmd(VSS_C_SWARM);
    repeat (3010) @(posedge clk);
    cmd(VSS_C_INIT);
    repeat (10) @(posedge clk);
    cmd(VSS_C_LOCKED);
    rdc(`VSS_A_ERROR, 32'h348);
    cmd(VSS_C_SWABORT);
    rdc(`VSS_A_SWSTATE, 32'h0);
    chkb(oper, 1'b0);
    n = vq.size();
    repeat (200) @(posedge clk);
    chk(32'(vq.size()), 32'(n));
    lat <= 8'h00;
    $display("abort done");
  endtask
  task automatic t_local();
    logic [31:0] r;
    rmt <= 1'b0;
    wr(`VSS_A_ARMCNT, 32'h0);
    cmd(VSS_C_TRIGKEY);
    repeat (20) @(posedge clk);
    chkb(idle, 1'b0);
    cmd(VSS_C_GENERIC);
    apb(1'b0, `VSS_A_STATUS, 32'h0, r);
    chkb(r[`VSS_ST_PEND], 1'b1);
    cmd(VSS_C_HALT);
    @(posedge clk);
    chkb(idle, 1'b1);
    cmd(VSS_C_TRIGKEY);
    cmd(VSS_C_RST);
    @(posedge clk);
    chkb(idle, 1'b1);
    rdc(`VSS_A_ARMCNT, 32'h1);
    rmt <= 1'b1;
    $display("local done");
  endtask
  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_arm_err();
    t_sweep(32'h0, 32'h2710, 4);
    t_sweep(32'h0, 32'hFFFF_E4A8, 3);
    t_abort();
    t_local();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
